// ===== sp_dp_pkg.sv
// package: register map, reset values and carriers for the stack and data pointer block
package sp_dp_pkg;
  localparam logic [7:0] stack_top_pointer_offset = 8'h81;
  localparam logic [7:0] indirect_pointer_low_offset = 8'h82;
  localparam logic [7:0] indirect_pointer_high_offset = 8'h83;
  localparam logic [7:0] core_ctrl_offset = 8'h84;
  localparam logic [7:0] stack_top_pointer_reset = 8'h07;
  localparam logic [7:0] indirect_pointer_low_reset = 8'h00;
  localparam logic [7:0] indirect_pointer_high_reset = 8'h00;
  localparam int page_width = 8;

  // core-side stack and pointer strobes
  typedef struct packed {
    logic push;
    logic pop;
    logic ptr_inc;
  } core_req_type;

  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_ack = 2'b01
  } bus_state_type;
endpackage : sp_dp_pkg

// ===== wb_reg_slave.sv
// wishbone classic slave: one-cycle ack, decodes the byte address into a register index
module wb_reg_slave
  import sp_dp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  output logic ack_o,
  output logic wr_pulse,
  output logic rd_pulse,
  output logic [7:0] reg_index,
  output logic lane_ok
);
  bus_state_type state;
  bus_state_type next_state;

  always_comb begin
    next_state = bus_idle;
    unique case (state)
      bus_idle: if (cyc_i && stb_i) next_state = bus_ack;
      bus_ack: next_state = bus_idle;
      default: next_state = bus_idle;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= bus_idle;
    end else begin
      state <= next_state;
    end
  end

  // ack stands one cycle; the master drops the strobe after seeing it
  assign ack_o = (state == bus_ack);
  assign wr_pulse = ack_o && we_i && cyc_i && stb_i;
  // a read is taken at the request edge so its data can stand beside ack
  assign rd_pulse = (state == bus_idle) && !we_i && cyc_i && stb_i;
  assign reg_index = adr_i[9:2];
  assign lane_ok = sel_i[0];
endmodule : wb_reg_slave

// ===== sp_dp_regs.sv
// stack pointer and data pointer register file with wishbone access
//
// Notes on behaviour
// RULE_01: the stack pointer holds the top of stack and is incremented before a push writes.
// RULE_02: any reset loads the stack pointer with 0x07 so the first push lands at eight.
// RULE_03: the three registers sit at 0x81, 0x82 and 0x83 on every register page.
// RULE_04: the low pointer register is bits 7 to 0 and its write touches only that byte.
// RULE_05: the high pointer register is bits 15 to 8 and its write touches only that byte.
// RULE_06: the 16-bit pointer addresses external data ram and program flash indirectly.
// RULE_07: software must never write a one into a reserved bit.
// RULE_08: undefined addresses such as 0x97, 0xa2, 0xb3, 0xb4, 0xce, 0xdf do nothing.
// RULE_09: the stack pointer is decremented after a pop or return read.
//
// Register access over Wishbone is this design's own decision.
module sp_dp_regs
  import sp_dp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [page_width-1:0] page_sel,
  input wire core_req_type core_req,
  output logic [7:0] stack_addr,
  output logic [15:0] indirect_pointer
);
  // ------------------------------------------------------------
  // bus front end
  // ------------------------------------------------------------
  logic wr_pulse;
  logic rd_pulse;
  logic [7:0] reg_index;
  logic lane_ok;
  logic ack_int;

  wb_reg_slave u_slave (
    .clock(clock),
    .rst(rst),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .ack_o(ack_int),
    .wr_pulse(wr_pulse),
    .rd_pulse(rd_pulse),
    .reg_index(reg_index),
    .lane_ok(lane_ok)
  );

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] stack_top_pointer;
  logic [7:0] indirect_pointer_low;
  logic [7:0] indirect_pointer_high;
  logic push_enable;
  logic [7:0] next_stack_top_pointer;
  logic [7:0] next_indirect_pointer_low;
  logic [7:0] next_indirect_pointer_high;
  logic next_push_enable;
  logic [31:0] next_dat_o;
  logic [7:0] next_stack_addr;
  logic [15:0] next_indirect_pointer;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] off);
    return idx == off;
  endfunction : hit

  // page_sel is deliberately ignored: these registers are on all pages
  logic page_unused;
  assign page_unused = ^page_sel;

  always_comb begin
    next_stack_top_pointer = stack_top_pointer;
    next_indirect_pointer_low = indirect_pointer_low;
    next_indirect_pointer_high = indirect_pointer_high;
    next_push_enable = push_enable;
    next_dat_o = 32'h0000_0000;
    // core strobes: push pre-increments, pop post-decrements
    if (core_req.push && push_enable && !core_req.pop) begin
      next_stack_top_pointer = stack_top_pointer + 8'h01; // see RULE_01
    end else if (core_req.pop && !core_req.push) begin
      next_stack_top_pointer = stack_top_pointer - 8'h01; // see RULE_09
    end
    if (core_req.ptr_inc) begin
      {next_indirect_pointer_high, next_indirect_pointer_low} =
        {indirect_pointer_high, indirect_pointer_low} + 16'h0001;
    end
    // software write wins over core update in the same cycle
    if (wr_pulse && lane_ok) begin
      if (hit(reg_index, stack_top_pointer_offset)) begin
        next_stack_top_pointer = dat_i[7:0]; // see RULE_03
      end else if (hit(reg_index, indirect_pointer_low_offset)) begin
        next_indirect_pointer_low = dat_i[7:0]; // see RULE_04
      end else if (hit(reg_index, indirect_pointer_high_offset)) begin
        next_indirect_pointer_high = dat_i[7:0]; // see RULE_05
      end else if (hit(reg_index, core_ctrl_offset)) begin
        next_push_enable = dat_i[0];
      end
      // other indices, reserved ones included, are ignored; see RULE_08
    end
    // read data launches at the request edge so that it stands beside ack
    if (rd_pulse) begin
      if (hit(reg_index, stack_top_pointer_offset)) begin
        next_dat_o = {24'h000000, stack_top_pointer}; // see RULE_03
      end else if (hit(reg_index, indirect_pointer_low_offset)) begin
        next_dat_o = {24'h000000, indirect_pointer_low};
      end else if (hit(reg_index, indirect_pointer_high_offset)) begin
        next_dat_o = {24'h000000, indirect_pointer_high};
      end else if (hit(reg_index, core_ctrl_offset)) begin
        next_dat_o = {31'h00000000, push_enable};
      end
    end
    // stack address seen by a push already carries the increment
    next_stack_addr = next_stack_top_pointer;
    next_indirect_pointer = {next_indirect_pointer_high, next_indirect_pointer_low}; // see RULE_06
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stack_top_pointer <= stack_top_pointer_reset; // see RULE_02
      indirect_pointer_low <= indirect_pointer_low_reset;
      indirect_pointer_high <= indirect_pointer_high_reset;
      push_enable <= 1'b1;
      dat_o <= 32'h0000_0000;
      stack_addr <= stack_top_pointer_reset;
      indirect_pointer <= 16'h0000;
    end else begin
      stack_top_pointer <= next_stack_top_pointer;
      indirect_pointer_low <= next_indirect_pointer_low;
      indirect_pointer_high <= next_indirect_pointer_high;
      push_enable <= next_push_enable;
      dat_o <= next_dat_o;
      stack_addr <= next_stack_addr;
      indirect_pointer <= next_indirect_pointer;
    end
  end

  // ack leaves the slave combinationally from its state flop
  assign ack_o = ack_int;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_push_inc;
    @(posedge clock) disable iff (rst)
      (core_req.push && !core_req.pop && push_enable && !wr_pulse)
      |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01;
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push did not increment"); // see RULE_01

  property p_reset_val;
    @(posedge clock) $fell(rst) |-> stack_top_pointer == 8'h07;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("stack reset value wrong"); // see RULE_02

  property p_read_sp;
    @(posedge clock) disable iff (rst)
      (rd_pulse && reg_index == 8'h81) |=> dat_o[7:0] == $past(stack_top_pointer);
  endproperty
  a_read_sp: assert property (p_read_sp) else $error("stack read wrong"); // see RULE_03

  property p_low_write;
    @(posedge clock) disable iff (rst)
      (wr_pulse && lane_ok && reg_index == 8'h82)
      |=> indirect_pointer_low == $past(dat_i[7:0])
          && indirect_pointer_high == $past(indirect_pointer_high);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low write wrong"); // see RULE_04

  property p_high_write;
    @(posedge clock) disable iff (rst)
      (wr_pulse && lane_ok && reg_index == 8'h83)
      |=> indirect_pointer_high == $past(dat_i[7:0])
          && indirect_pointer_low == $past(indirect_pointer_low);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high write wrong"); // see RULE_05

  property p_ptr_out;
    @(posedge clock) disable iff (rst)
      indirect_pointer == {indirect_pointer_high, indirect_pointer_low};
  endproperty
  a_ptr_out: assert property (p_ptr_out) else $error("pointer output mismatch"); // see RULE_06

  property p_reserved;
    @(posedge clock) disable iff (rst)
      (wr_pulse && reg_index == 8'h97 && !core_req.push && !core_req.pop && !core_req.ptr_inc)
      |=> $stable(stack_top_pointer) && $stable(indirect_pointer);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved write had effect"); // see RULE_08

  property p_pop_dec;
    @(posedge clock) disable iff (rst)
      (core_req.pop && !core_req.push && !wr_pulse)
      |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01;
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("pop did not decrement"); // see RULE_09

  // ------------------------------------------------------------
  // bus, reset and pointer checks
  // ------------------------------------------------------------
  // these watch the outputs stack_addr, indirect_pointer, dat_o and ack_o, except p_push_pop, p_push_off and p_lane_off, which watch stack_top_pointer
  property p_ptr_inc;
    @(posedge clock) disable iff (rst)
      (core_req.ptr_inc && !wr_pulse)
      |=> indirect_pointer == $past(indirect_pointer) + 16'h0001;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not step"); // see RULE_06

  property p_ptr_hold;
    @(posedge clock) disable iff (rst)
      (!core_req.ptr_inc && !wr_pulse) |=> $stable(indirect_pointer);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved alone"); // see RULE_06

  property p_push_addr;
    @(posedge clock) disable iff (rst)
      (core_req.push && !core_req.pop && push_enable && !wr_pulse)
      |=> stack_addr == $past(stack_top_pointer) + 8'h01;
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push address wrong"); // see RULE_01

  property p_pop_addr;
    @(posedge clock) disable iff (rst)
      (core_req.pop && !core_req.push && !wr_pulse)
      |=> stack_addr == $past(stack_top_pointer) - 8'h01;
  endproperty
  a_pop_addr: assert property (p_pop_addr) else $error("pop address wrong"); // see RULE_09

  property p_push_pop;
    @(posedge clock) disable iff (rst)
      (core_req.push && core_req.pop && !wr_pulse) |=> $stable(stack_top_pointer);
  endproperty
  a_push_pop: assert property (p_push_pop) else $error("push with pop moved stack"); // see RULE_01

  // a gated push must not leave the stack half updated
  property p_push_off;
    @(posedge clock) disable iff (rst)
      (core_req.push && !core_req.pop && !push_enable && !wr_pulse)
      |=> $stable(stack_top_pointer);
  endproperty
  a_push_off: assert property (p_push_off) else $error("gated push moved stack"); // see RULE_01

  property p_reset_addr;
    @(posedge clock) $fell(rst) |-> stack_addr == stack_top_pointer_reset;
  endproperty
  a_reset_addr: assert property (p_reset_addr) else $error("stack address reset wrong"); // see RULE_02

  property p_reset_ptr;
    @(posedge clock)
      $fell(rst) |-> indirect_pointer == {indirect_pointer_high_reset, indirect_pointer_low_reset};
  endproperty
  a_reset_ptr: assert property (p_reset_ptr) else $error("pointer reset wrong"); // see RULE_06

  property p_read_low;
    @(posedge clock) disable iff (rst)
      (rd_pulse && reg_index == 8'h82) |=> dat_o[7:0] == $past(indirect_pointer_low);
  endproperty
  a_read_low: assert property (p_read_low) else $error("low read wrong"); // see RULE_04

  property p_read_high;
    @(posedge clock) disable iff (rst)
      (rd_pulse && reg_index == 8'h83) |=> dat_o[7:0] == $past(indirect_pointer_high);
  endproperty
  a_read_high: assert property (p_read_high) else $error("high read wrong"); // see RULE_05

  property p_read_reserved;
    @(posedge clock) disable iff (rst)
      (rd_pulse && reg_index == 8'h97) |=> dat_o == 32'h0000_0000;
  endproperty
  a_read_reserved: assert property (p_read_reserved) else $error("reserved read not zero"); // see RULE_08

  property p_read_ctrl;
    @(posedge clock) disable iff (rst)
      (rd_pulse && reg_index == core_ctrl_offset) |=> dat_o[31:1] == 31'h00000000;
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control spare bits set"); // see RULE_08

  property p_upper_zero;
    @(posedge clock) disable iff (rst)
      dat_o[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set"); // see RULE_03

  property p_ack_one;
    @(posedge clock) disable iff (rst)
      ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle"); // see RULE_03

  property p_ack_follows;
    @(posedge clock) disable iff (rst)
      (cyc_i && stb_i && !ack_o) |=> ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("request not acked"); // see RULE_03

  property p_idle_ack;
    @(posedge clock) disable iff (rst)
      (!(cyc_i && stb_i) && !ack_o) |=> !ack_o;
  endproperty
  a_idle_ack: assert property (p_idle_ack) else $error("ack without request"); // see RULE_03

  property p_lane_off;
    @(posedge clock) disable iff (rst)
      (wr_pulse && !lane_ok && !core_req.push && !core_req.pop && !core_req.ptr_inc)
      |=> $stable(stack_top_pointer) && $stable(indirect_pointer);
  endproperty
  a_lane_off: assert property (p_lane_off) else $error("masked write had effect"); // see RULE_04
endmodule : sp_dp_regs

// ===== sp_dp_regs_test.sv
// self-checking bench for the stack and data pointer register file
module sp_dp_regs_test
  import sp_dp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] d;
    logic [7:0] rd;
    logic [15:0] ptr;
    logic [7:0] sp;
  } row_type;
  logic clock, rst, cyc_i, stb_i, we_i, ack_o;
  logic [9:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic [7:0] page_sel, stack_addr, rd;
  logic [15:0] indirect_pointer;
  core_req_type core_req;
  int bad_count, n_compared;
  // unmapped rows must read zero and leave the pointer alone
  row_type rows[10] = '{
    '{8'h81, 8'h3c, 8'h3c, 16'h0000, 8'h3c}, '{8'h82, 8'ha5, 8'ha5, 16'h00a5, 8'h3c},
    '{8'h83, 8'h5a, 8'h5a, 16'h5aa5, 8'h3c}, '{8'h82, 8'hff, 8'hff, 16'h5aff, 8'h3c},
    '{8'h97, 8'hff, 8'h00, 16'h5aff, 8'h3c}, '{8'ha2, 8'hff, 8'h00, 16'h5aff, 8'h3c},
    '{8'hb3, 8'hff, 8'h00, 16'h5aff, 8'h3c}, '{8'hb4, 8'hff, 8'h00, 16'h5aff, 8'h3c},
    '{8'hce, 8'hff, 8'h00, 16'h5aff, 8'h3c}, '{8'hdf, 8'hff, 8'h00, 16'h5aff, 8'h3c}};

  sp_dp_regs dut (.clock(clock), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .page_sel(page_sel), .core_req(core_req), .stack_addr(stack_addr),
    .indirect_pointer(indirect_pointer));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare

  // read data stands beside ack, so it is taken at the edge that sees ack
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] s, output logic [7:0] q);
    int n;
    @(posedge clock);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= s;
    dat_i <= {24'h000000, d};
    n = 0;
    @(posedge clock);
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    q = dat_o[7:0];
    if (n >= 20) begin
      bad_count++;
      $display("MISMATCH at %0t: no ack", $time);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb

  task automatic pulse(input logic [2:0] r);
    @(posedge clock);
    core_req <= r;
    @(posedge clock);
    core_req <= 3'b000;
    @(posedge clock);
  endtask : pulse

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4000) @(posedge clock);
    bad_count++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, page_sel} = '0;
    core_req = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    compare({8'h00, stack_addr}, 16'h0007);
    compare(indirect_pointer, 16'h0000);
    wb(1'b0, 8'h81, 8'h00, 4'hf, rd);
    compare({8'h00, rd}, 16'h0007);
    $display("reset values done");
    foreach (rows[i]) begin
      page_sel <= 8'(i * 37);
      wb(1'b1, rows[i].idx, rows[i].d, 4'h1, rd);
      wb(1'b0, rows[i].idx, 8'h00, 4'h1, rd);
      compare({8'h00, rd}, {8'h00, rows[i].rd});
      compare(indirect_pointer, rows[i].ptr);
      compare({8'h00, stack_addr}, {8'h00, rows[i].sp});
    end
    $display("register rows done");
    pulse(3'b100);
    compare({8'h00, stack_addr}, 16'h003d);
    pulse(3'b010);
    compare({8'h00, stack_addr}, 16'h003c);
    pulse(3'b110);
    compare({8'h00, stack_addr}, 16'h003c);
    pulse(3'b001);
    compare(indirect_pointer, 16'h5b00);
    wb(1'b1, 8'h82, 8'h77, 4'he, rd);
    compare(indirect_pointer, 16'h5b00);
    wb(1'b1, 8'h84, 8'h00, 4'h1, rd);
    pulse(3'b100);
    compare({8'h00, stack_addr}, 16'h003c);
    wb(1'b1, 8'h84, 8'h01, 4'h1, rd);
    wb(1'b0, 8'h84, 8'h00, 4'h1, rd);
    compare({8'h00, rd}, 16'h0001);
    $display("core strobes done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    compare({8'h00, stack_addr}, 16'h0007);
    compare(indirect_pointer, 16'h0000);
    pulse(3'b100);
    compare({8'h00, stack_addr}, 16'h0008);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule : sp_dp_regs_test
